// ==== bsc_chain.sv ====
// Functional notes
// - Each cell holds output, enable and input bits, each with a capture stage; only user I/O cells add an update stage.
// - Capture stages sample core output, core enable and pad input.
// - Update stages drive pad output and enable while override is active.
// - Shift, capture and update strobes come from the internal TAP state only.
// - Override select is decoded from the current instruction register.
// - Scan data moves cell to cell, from TDI through the chain to TDO.
// - JTAG, supply and reference pins carry no cell and stay out of the chain.
// - Clock input cell captures 0, 1, pad; no update; pad feeds clock net.
// - Dedicated input cell captures 0, 1, pad; no update; pad feeds control logic.
// - Open-drain bidirectional cell captures 0, core enable, pad; no update.
// - Push-pull bidirectional cell captures core out, enable, pad; core drives buffer.
// - Dedicated output cell captures core out, 0, 0; no update.
// - The register is one long serial path of three-bit cells on user and dedicated pad pins.
// - In external test an update enable of 0 drives the update value out.
//
// Purpose : Boundary-scan cell chain with its own TAP tracker, sampled on the system clock.
// Assumes : TCK is far slower than clk (at least four clk periods per TCK half period).
// Notes   : Every capture pushes a snapshot word into a FIFO; a full FIFO drops it.
`default_nettype none

module bsc_chain #(
   parameter int                       NUM_CELLS   = 8,
   parameter logic [3*NUM_CELLS-1:0]   CELL_TYPES  = '0,
   parameter logic [bsc_pkg::BSC_IR_W-1:0] EXTEST_CODE = bsc_pkg::BSC_EXTEST_DFLT,
   parameter logic [bsc_pkg::BSC_IR_W-1:0] SAMPLE_CODE = bsc_pkg::BSC_SAMPLE_DFLT,
   parameter int                       SNAP_DEPTH  = bsc_pkg::BSC_SNAP_DEPTH
) (
   input  wire logic                                     clk,
   input  wire logic                                     reset,
   input  wire logic                                     tck,
   input  wire logic                                     tms,
   input  wire logic                                     tdi,
   output logic                                          tdo,
   output logic                                          tdo_oe,
   input  wire logic [NUM_CELLS-1:0]                     pad_in,
   output logic      [NUM_CELLS-1:0]                     pad_out,
   output logic      [NUM_CELLS-1:0]                     pad_oe,
   input  wire logic [NUM_CELLS-1:0]                     core_output_value,
   input  wire logic [NUM_CELLS-1:0]                     core_output_enable_n,
   output logic      [NUM_CELLS-1:0]                     core_input_value,
   output logic                                          snap_valid,
   output bsc_pkg::bsc_cell_bits_t [NUM_CELLS-1:0]       snap_data,
   input  wire logic                                     snap_ready,
   output logic                                          snap_space
);
   import bsc_pkg::*;

   localparam int L = BSC_CELL_BITS * NUM_CELLS;

   // One clock domain for every check in this module, cell checks included
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ----------------------------------------------------------------
   // Pin synchronisers and TCK edge detection
   // ----------------------------------------------------------------
   logic [2:0]           jtag_s1_r;
   logic [2:0]           jtag_s2_r;
   logic                 tck_d_r;
   logic [NUM_CELLS-1:0] pad_s1_r;
   logic [NUM_CELLS-1:0] pad_s2_r;
   wire                  tck_s;
   wire                  tms_s;
   wire                  tdi_s;
   wire                  tck_rise;
   wire                  tck_fall;

   // Two flops on every pin before any logic looks at it
   always_ff @(posedge clk) begin
      if (reset) begin
         jtag_s1_r <= 3'h0;
         jtag_s2_r <= 3'h0;
         tck_d_r   <= 1'h0;
         pad_s1_r  <= '0;
         pad_s2_r  <= '0;
      end else begin
         jtag_s1_r <= {tck, tms, tdi};
         jtag_s2_r <= jtag_s1_r;
         tck_d_r   <= tck_s;
         pad_s1_r  <= pad_in;
         pad_s2_r  <= pad_s1_r;
      end
   end

   // TMS and TDI share the TCK delay, so they are valid at the detected edge
   assign tck_s    = jtag_s2_r[2];
   assign tms_s    = jtag_s2_r[1];
   assign tdi_s    = jtag_s2_r[0];
   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;

   // ----------------------------------------------------------------
   // TAP state tracker
   // ----------------------------------------------------------------
   bsc_tap_state_t tap_r;
   bsc_tap_state_t tap_nxt;

   // Standard sixteen-state walk steered by TMS
   always_comb begin
      unique case (tap_r)
         BSC_TAP_TLR:    tap_nxt = tms_s ? BSC_TAP_TLR    : BSC_TAP_RTI;
         BSC_TAP_RTI:    tap_nxt = tms_s ? BSC_TAP_SEL_DR : BSC_TAP_RTI;
         BSC_TAP_SEL_DR: tap_nxt = tms_s ? BSC_TAP_SEL_IR : BSC_TAP_CAP_DR;
         BSC_TAP_CAP_DR: tap_nxt = tms_s ? BSC_TAP_EX1_DR : BSC_TAP_SH_DR;
         BSC_TAP_SH_DR:  tap_nxt = tms_s ? BSC_TAP_EX1_DR : BSC_TAP_SH_DR;
         BSC_TAP_EX1_DR: tap_nxt = tms_s ? BSC_TAP_UPD_DR : BSC_TAP_PAU_DR;
         BSC_TAP_PAU_DR: tap_nxt = tms_s ? BSC_TAP_EX2_DR : BSC_TAP_PAU_DR;
         BSC_TAP_EX2_DR: tap_nxt = tms_s ? BSC_TAP_UPD_DR : BSC_TAP_SH_DR;
         BSC_TAP_UPD_DR: tap_nxt = tms_s ? BSC_TAP_SEL_DR : BSC_TAP_RTI;
         BSC_TAP_SEL_IR: tap_nxt = tms_s ? BSC_TAP_TLR    : BSC_TAP_CAP_IR;
         BSC_TAP_CAP_IR: tap_nxt = tms_s ? BSC_TAP_EX1_IR : BSC_TAP_SH_IR;
         BSC_TAP_SH_IR:  tap_nxt = tms_s ? BSC_TAP_EX1_IR : BSC_TAP_SH_IR;
         BSC_TAP_EX1_IR: tap_nxt = tms_s ? BSC_TAP_UPD_IR : BSC_TAP_PAU_IR;
         BSC_TAP_PAU_IR: tap_nxt = tms_s ? BSC_TAP_EX2_IR : BSC_TAP_PAU_IR;
         BSC_TAP_EX2_IR: tap_nxt = tms_s ? BSC_TAP_UPD_IR : BSC_TAP_SH_IR;
         BSC_TAP_UPD_IR: tap_nxt = tms_s ? BSC_TAP_SEL_DR : BSC_TAP_RTI;
      endcase
   end

   // State moves only on a detected TCK rise
   always_ff @(posedge clk) begin
      if (reset) begin
         tap_r <= BSC_TAP_TLR;
      end else if (tck_rise) begin
         tap_r <= tap_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Instruction register and override decode
   // ----------------------------------------------------------------
   logic [BSC_IR_W-1:0] ir_shift_r;
   logic [BSC_IR_W-1:0] ir_active_r;
   logic                mode_r;
   wire                 bsr_sel;

   // Both sample and external test route the data register to the cells
   assign bsr_sel = (ir_active_r == EXTEST_CODE) | (ir_active_r == SAMPLE_CODE);

   // Shift on rise, take effect on the falling edge in update
   always_ff @(posedge clk) begin
      if (reset) begin
         ir_shift_r  <= BSC_IR_RESET;
         ir_active_r <= BSC_IR_RESET;
         mode_r      <= 1'h0;
      end else begin
         if (tck_rise && tap_r == BSC_TAP_CAP_IR) begin
            ir_shift_r <= BSC_IR_CAPTURE;
         end else if (tck_rise && tap_r == BSC_TAP_SH_IR) begin
            ir_shift_r <= {tdi_s, ir_shift_r[BSC_IR_W-1:1]};
         end
         if (tap_r == BSC_TAP_TLR) begin
            ir_active_r <= BSC_IR_RESET;
         end else if (tck_fall && tap_r == BSC_TAP_UPD_IR) begin
            ir_active_r <= ir_shift_r;
         end
         mode_r <= (ir_active_r == EXTEST_CODE);
      end
   end

   // ----------------------------------------------------------------
   // Capture and shift path
   // ----------------------------------------------------------------
   // Only pad cells are in this path; JTAG, supply and reference pins have none
   bsc_cell_bits_t [NUM_CELLS-1:0] cap_vec;
   logic [L-1:0]                   chain_r;
   logic                           bypass_r;
   logic                           tdo_r;
   logic                           tdo_oe_r;
   wire                            cap_ev;
   wire                            shift_ev;
   wire                            upd_ev;

   // Strobes are decoded here and never come from a pin
   assign cap_ev   = tck_rise & (tap_r == BSC_TAP_CAP_DR) & bsr_sel;
   assign shift_ev = tck_rise & (tap_r == BSC_TAP_SH_DR) & bsr_sel;
   assign upd_ev   = tck_fall & (tap_r == BSC_TAP_UPD_DR) & bsr_sel;

   // Cell 0 sits next to TDO; TDI enters the top cell
   always_ff @(posedge clk) begin
      if (reset) begin
         chain_r  <= '0;
         bypass_r <= 1'h0;
      end else begin
         if (cap_ev) begin
            chain_r <= cap_vec;
         end else if (shift_ev) begin
            chain_r <= {tdi_s, chain_r[L-1:1]};
         end
         if (tck_rise && tap_r == BSC_TAP_CAP_DR) begin
            bypass_r <= 1'h0;
         end else if (tck_rise && tap_r == BSC_TAP_SH_DR) begin
            bypass_r <= tdi_s;
         end
      end
   end

   // TDO changes on the falling edge and is enabled only while shifting
   always_ff @(posedge clk) begin
      if (reset) begin
         tdo_r    <= 1'h0;
         tdo_oe_r <= 1'h0;
      end else if (tck_fall) begin
         tdo_oe_r <= (tap_r == BSC_TAP_SH_DR) | (tap_r == BSC_TAP_SH_IR);
         if (tap_r == BSC_TAP_SH_IR) begin
            tdo_r <= ir_shift_r[0];
         end else if (tap_r == BSC_TAP_SH_DR) begin
            tdo_r <= bsr_sel ? chain_r[0] : bypass_r;
         end
      end
   end

   assign tdo    = tdo_r;
   assign tdo_oe = tdo_oe_r;

   // ----------------------------------------------------------------
   // Per-cell wiring by pin kind
   // ----------------------------------------------------------------
   logic [NUM_CELLS-1:0] pad_out_nxt;
   logic [NUM_CELLS-1:0] pad_oe_nxt;
   logic [NUM_CELLS-1:0] cin_nxt;
   logic [NUM_CELLS-1:0] pad_out_r;
   logic [NUM_CELLS-1:0] pad_oe_r;
   logic [NUM_CELLS-1:0] cin_r;

   for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
      localparam bsc_pin_type_t T = bsc_pin_type_t'(CELL_TYPES[3*i +: 3]);
      if (T == BSC_PIN_USER_IO) begin : g_user
         logic [2:0] upd_r;

         // Update stage holds except on the falling edge in update
         always_ff @(posedge clk) begin
            if (reset) begin
               upd_r <= BSC_UPD_RESET;
            end else if (upd_ev) begin
               upd_r <= chain_r[3*i +: 3];
            end
         end

         // Override picks update data over core data at the pad
         assign cap_vec[i]     = {pad_s2_r[i], core_output_enable_n[i], core_output_value[i]};
         assign pad_out_nxt[i] = mode_r ? upd_r[BSC_POS_OUT] : core_output_value[i];
         assign pad_oe_nxt[i]  = ~(mode_r ? upd_r[BSC_POS_OE] : core_output_enable_n[i]);
         assign cin_nxt[i]     = mode_r ? upd_r[BSC_POS_IN] : pad_s2_r[i];

         property p_update_hold;
            !$stable(upd_r) |-> $past(upd_ev);
         endproperty
         a_update_hold: assert property (p_update_hold) else $error("update stage moved off update edge");

         property p_override_out;
            mode_r |=> pad_out_r[i] == $past(upd_r[BSC_POS_OUT]);
         endproperty
         a_override_out: assert property (p_override_out) else $error("pad output ignores update stage");

         property p_oe_drive;
            mode_r && !upd_r[BSC_POS_OE] |=> pad_oe_r[i];
         endproperty
         a_oe_drive: assert property (p_oe_drive) else $error("update enable 0 did not drive pad");
      end else if (T == BSC_PIN_CLK_IN || T == BSC_PIN_DED_IN) begin : g_in
         // Input-only pin: fixed capture, pad feeds clock net or control logic
         assign cap_vec[i]     = {pad_s2_r[i], 1'h1, 1'h0};
         assign pad_out_nxt[i] = 1'h0;
         assign pad_oe_nxt[i]  = 1'h0;
         assign cin_nxt[i]     = pad_s2_r[i];

         property p_in_capture;
            cap_ev |=> chain_r[3*i+BSC_POS_OE] && !chain_r[3*i+BSC_POS_OUT]
                       && chain_r[3*i+BSC_POS_IN] == $past(pad_s2_r[i]);
         endproperty
         a_in_capture: assert property (p_in_capture) else $error("input cell capture wrong");
      end else if (T == BSC_PIN_OD_BIDIR) begin : g_od
         // Open drain only ever pulls low when the core enables it
         assign cap_vec[i]     = {pad_s2_r[i], core_output_enable_n[i], 1'h0};
         assign pad_out_nxt[i] = 1'h0;
         assign pad_oe_nxt[i]  = ~core_output_enable_n[i];
         assign cin_nxt[i]     = pad_s2_r[i];
      end else if (T == BSC_PIN_PP_BIDIR) begin : g_pp
         // Core value drives the buffer; scan never overrides it
         assign cap_vec[i]     = {pad_s2_r[i], core_output_enable_n[i], core_output_value[i]};
         assign pad_out_nxt[i] = core_output_value[i];
         assign pad_oe_nxt[i]  = ~core_output_enable_n[i];
         assign cin_nxt[i]     = pad_s2_r[i];
      end else begin : g_out
         // Output-only pin: driven except during reset, nothing comes back in
         assign cap_vec[i]     = {1'h0, 1'h0, core_output_value[i]};
         assign pad_out_nxt[i] = core_output_value[i];
         assign pad_oe_nxt[i]  = 1'h1;
         assign cin_nxt[i]     = 1'h0;

         property p_out_capture;
            cap_ev |=> !chain_r[3*i+BSC_POS_OE] && !chain_r[3*i+BSC_POS_IN]
                       && chain_r[3*i+BSC_POS_OUT] == $past(core_output_value[i]);
         endproperty
         a_out_capture: assert property (p_out_capture) else $error("output cell capture wrong");
      end
   end

   // Registered pad and core-side outputs, one cycle behind the selection
   always_ff @(posedge clk) begin
      if (reset) begin
         pad_out_r <= '0;
         pad_oe_r  <= '0;
         cin_r     <= '0;
      end else begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r  <= pad_oe_nxt;
         cin_r     <= cin_nxt;
      end
   end

   assign pad_out          = pad_out_r;
   assign pad_oe           = pad_oe_r;
   assign core_input_value = cin_r;

   // ----------------------------------------------------------------
   // Snapshot buffer
   // ----------------------------------------------------------------
   // The TAP cannot be stalled, so a capture meeting a full FIFO is lost
   bsc_fifo #(
      .WIDTH (L),
      .DEPTH (SNAP_DEPTH)
   ) u_snap_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (cap_ev),
      .in_data   (cap_vec),
      .in_ready  (snap_space),
      .out_valid (snap_valid),
      .out_data  (snap_data),
      .out_ready (snap_ready)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_capture;
      cap_ev |=> chain_r == $past(cap_vec);
   endproperty
   a_capture: assert property (p_capture) else $error("capture did not load sampled values");

   property p_shift;
      shift_ev |=> chain_r[L-1] == $past(tdi_s) && chain_r[L-2:0] == $past(chain_r[L-1:1]);
   endproperty
   a_shift: assert property (p_shift) else $error("chain did not shift one place");

   property p_chain_quiet;
      !$stable(chain_r) |-> $past(tck_rise && tap_r inside {BSC_TAP_CAP_DR, BSC_TAP_SH_DR});
   endproperty
   a_chain_quiet: assert property (p_chain_quiet) else $error("chain moved without TAP strobe");

   property p_mode;
      $changed(ir_active_r) |=> mode_r == ($past(ir_active_r) == EXTEST_CODE);
   endproperty
   a_mode: assert property (p_mode) else $error("override select not decoded from instruction");

   property p_tdo;
      tck_fall && tap_r == BSC_TAP_SH_DR && bsr_sel |=> tdo_oe && tdo == $past(chain_r[0]);
   endproperty
   a_tdo: assert property (p_tdo) else $error("TDO does not present chain end");
endmodule

`default_nettype wire

// ==== bsc_fifo.sv ====
// Purpose : Shared constants and types for the boundary-scan cell chain, plus its snapshot FIFO.
// Assumes : Single clock domain for the FIFO; synchronous active-high reset.
// Notes   : FIFO read data come out of a register; full and empty are honest.
`default_nettype none

package bsc_pkg;
   // ----------------------------------------------------------------
   // Cell layout
   // ----------------------------------------------------------------
   localparam int BSC_CELL_BITS = 3;
   localparam int BSC_POS_OUT   = 0;       // Output value bit within a cell
   localparam int BSC_POS_OE    = 1;       // Output enable bit, active low
   localparam int BSC_POS_IN    = 2;       // Input value bit

   // Update stage reset value: pad released (enable bit high), data low
   localparam logic [2:0] BSC_UPD_RESET = 3'h2;

   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   localparam int          BSC_IR_W        = 10;
   localparam logic [9:0]  BSC_IR_RESET    = 10'h3FF;   // Bypass after test-logic reset
   localparam logic [9:0]  BSC_IR_CAPTURE  = 10'h001;   // Shifts out 1 then 0 first
   localparam logic [9:0]  BSC_EXTEST_DFLT = 10'h00F;   // Arbitrary value, set per part
   localparam logic [9:0]  BSC_SAMPLE_DFLT = 10'h005;   // Arbitrary value, set per part

   // Snapshot buffer depth
   localparam int BSC_SNAP_DEPTH = 16;

   // Pin kinds that a cell may sit on
   typedef enum logic [2:0] {
      BSC_PIN_USER_IO  = 3'h0,
      BSC_PIN_CLK_IN   = 3'h1,
      BSC_PIN_DED_IN   = 3'h2,
      BSC_PIN_OD_BIDIR = 3'h3,
      BSC_PIN_PP_BIDIR = 3'h4,
      BSC_PIN_DED_OUT  = 3'h5
   } bsc_pin_type_t;

   // TAP controller states
   typedef enum logic [3:0] {
      BSC_TAP_TLR      = 4'h0,
      BSC_TAP_RTI      = 4'h1,
      BSC_TAP_SEL_DR   = 4'h2,
      BSC_TAP_CAP_DR   = 4'h3,
      BSC_TAP_SH_DR    = 4'h4,
      BSC_TAP_EX1_DR   = 4'h5,
      BSC_TAP_PAU_DR   = 4'h6,
      BSC_TAP_EX2_DR   = 4'h7,
      BSC_TAP_UPD_DR   = 4'h8,
      BSC_TAP_SEL_IR   = 4'h9,
      BSC_TAP_CAP_IR   = 4'hA,
      BSC_TAP_SH_IR    = 4'hB,
      BSC_TAP_EX1_IR   = 4'hC,
      BSC_TAP_PAU_IR   = 4'hD,
      BSC_TAP_EX2_IR   = 4'hE,
      BSC_TAP_UPD_IR   = 4'hF
   } bsc_tap_state_t;

   // Three bits of one cell, matching the field positions above
   typedef struct packed {
      logic in_val;
      logic oe_n;
      logic out_val;
   } bsc_cell_bits_t;
endpackage

// ----------------------------------------------------------------
// Snapshot FIFO
// ----------------------------------------------------------------
module bsc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   import bsc_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]   FULL_CNT = AW'(0) + (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             out_valid_r;
   logic [WIDTH-1:0] out_data_r;
   wire              push;
   wire              pop;

   // Refill the output register whenever it is empty or being drained
   assign in_ready  = (count_r != FULL_CNT);
   assign push      = in_valid & in_ready;
   assign pop       = (count_r != '0) & (~out_valid_r | out_ready);
   assign out_valid = out_valid_r;
   assign out_data  = out_data_r;

   // Storage array, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // Pointers, fill count and registered read data
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_r    <= '0;
         rd_ptr_r    <= '0;
         count_r     <= '0;
         out_valid_r <= 1'h0;
         out_data_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'h1;
         end
         if (pop) begin
            rd_ptr_r   <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'h1;
            out_data_r <= mem_r[rd_ptr_r];
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
         if (pop) begin
            out_valid_r <= 1'h1;
         end else if (out_ready) begin
            out_valid_r <= 1'h0;
         end
      end
   end
endmodule

`default_nettype wire

// ==== bsc_jtag_host.sv ====
// Purpose : Test controller model driving the scan port of the cell chain.
// Assumes : TCK period 160 ns; TCK stands low between frames.
// Notes   : TDO is taken just before each TCK rise.
`default_nettype none
module bsc_jtag_host (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
   end
   // -----------------------------------------------------------
   // One TCK period: TDI set while TCK low, TDO taken before rise
   // -----------------------------------------------------------
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #80;
      q   = tdo;
      tck = 1'h1;
      #80;
      tck = 1'h0;
   endtask
   // Idle to shift, n bits LSB first, through update back to idle
   task automatic scan(input logic ir, input int n, input logic [17:0] din, output logic [17:0] dout);
      logic q;
      dout = '0;
      step(1'h1, 1'h0, q);
      if (ir) step(1'h1, 1'h0, q);
      step(1'h0, 1'h0, q);
      step(1'h0, 1'h0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'h1, 1'h0, q);
      step(1'h0, 1'h0, q);
   endtask
endmodule
`default_nettype wire

// ==== boundary_scan_cell_chain_tb.sv ====
// Purpose : Self-checking bench for the cell chain.
// Assumes : Cells 0..5 are user, clock in, input, open-drain, push-pull, output.
// Notes   : Snapshot words are compared with the scanned-out captures.
`default_nettype none
module boundary_scan_cell_chain_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import bsc_pkg::*;
   localparam int N = 6;
   localparam logic [17:0] TYPES = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
   typedef struct packed {logic o; logic e; logic p; logic [17:0] cap; logic [5:0] po; logic [5:0] poe;} bsc_row_t;
   logic clk = 1'h0, reset = 1'h1, snap_ready = 1'h0, tck, tms, tdi, tdo, tdo_oe, snap_valid, snap_space;
   logic [N-1:0] pad_in = '0, cov = '0, coe_n = '1, pad_out, pad_oe, cin;
   bsc_cell_bits_t [N-1:0] snap_data;
   logic [17:0] q;
   int n_mismatch = 0, num_checks = 0, k;
   bsc_row_t rows [4] = '{'{1'h1, 1'h0, 1'h1, 18'h0D9B5, 6'h31, 6'h39}, '{1'h0, 1'h1, 1'h0, 18'h02492, 6'h00, 6'h20},
                          '{1'h1, 1'h1, 1'h0, 18'h0B493, 6'h31, 6'h20}, '{1'h0, 1'h0, 1'h1, 18'h049B4, 6'h00, 6'h39}};
   bsc_chain #(.NUM_CELLS(N), .CELL_TYPES(TYPES)) i_bsc_chain (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .core_output_value(cov), .core_output_enable_n(coe_n), .core_input_value(cin), .snap_valid(snap_valid),
      .snap_data(snap_data), .snap_ready(snap_ready), .snap_space(snap_space));
   bsc_jtag_host i_bsc_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   always #5 clk = ~clk;
   // -----------------------------------------------------------
   // Checking and closing
   // -----------------------------------------------------------
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Wait for settled outputs after an edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   initial begin
      tick(10);
      chk({tdo_oe, snap_valid, snap_space, pad_oe}, 18'h00040);
      reset = 1'h0;
      tick(2);
      i_bsc_jtag_host.step(1'h0, 1'h0, q[0]);
      i_bsc_jtag_host.scan(1'h0, 2, 18'h3, q);
      chk({snap_valid, q[1:0]}, 18'h2);
      i_bsc_jtag_host.scan(1'h1, BSC_IR_W, 18'(BSC_SAMPLE_DFLT), q);
      chk(q[1:0], 18'h1);
      // Table rows: core mode pads, then capture by pin kind
      foreach (rows[i]) begin
         cov = {N{rows[i].o}};
         coe_n = {N{rows[i].e}};
         pad_in = {N{rows[i].p}};
         tick(4);
         chk({pad_out, pad_oe}, {rows[i].po, rows[i].poe});
         chk(cin, {13'h0, {5{rows[i].p}}});
         i_bsc_jtag_host.scan(1'h0, 3 * N, 18'h0, q);
         chk(q, rows[i].cap);
         chk(snap_data, rows[i].cap);
         chk(snap_valid, 1'h1);
         snap_ready = 1'h1;
         tick(1);
         snap_ready = 1'h0;
      end
      // External test: preloaded zeros drive the user pad, then scanned values
      i_bsc_jtag_host.scan(1'h1, BSC_IR_W, 18'(BSC_EXTEST_DFLT), q);
      tick(4);
      chk({pad_out, pad_oe}, 18'h039);
      i_bsc_jtag_host.scan(1'h0, 3 * N, 18'h1, q);
      chk({pad_out, pad_oe}, 18'h079);
      chk(cin, 18'h01E);
      i_bsc_jtag_host.scan(1'h0, 3 * N, 18'h3, q);
      chk({pad_out, pad_oe}, 18'h078);
      // Overfill the snapshot FIFO, then drain it in one burst
      for (k = 0; k < 17; k++) begin
         i_bsc_jtag_host.scan(1'h0, 1, 18'h0, q);
      end
      chk(snap_space, 1'h0);
      k = 0;
      repeat (60) begin
         if (snap_valid === 1'h1) k++;
         snap_ready = 1'h1;
         tick(1);
      end
      chk({snap_space, snap_valid, 16'(k)}, {2'h2, 16'd17});
      // Mid-run reset: everything released, then core mode again
      reset = 1'h1;
      tick(2);
      chk({tdo_oe, snap_valid, snap_space, pad_out, pad_oe}, 18'h01000);
      reset = 1'h0;
      tick(4);
      chk({cin, pad_out, pad_oe}, 18'h1F039);
      tally_and_finish();
   end
endmodule
`default_nettype wire
